// [common/sfe_cfg.svh]
// register offsets, field positions, reset values and sizes of the forwarding engine
`ifndef SFE_CFG_SVH
`define SFE_CFG_SVH

`define SFE_NPORT          4
`define SFE_DATA_W         32
`define SFE_FIFO_DEPTH     8

`define SFE_ADDR_PORT_CTL  8'h20
`define SFE_ADDR_MODE_CTL  8'h21
`define SFE_ADDR_STATUS    8'h35

`define SFE_PORT_CTL_RST   8'h00
`define SFE_MODE_CTL_RST   8'h01

`define SFE_DIS_LSB        0
`define SFE_MAP_LSB        4
`define SFE_RR_EN_BIT      0
`define SFE_SYNC_LSB       4
`define SFE_STS_SYNC_BIT   0
`define SFE_STS_LOST_BIT   1

`define SFE_SMODE_OFF      2'h0
`define SFE_SMODE_BASIC    2'h1
`define SFE_SMODE_ILV      2'h2
`define SFE_SMODE_CAT      2'h3

`endif

// [common/sfe_pkg.sv]
// types shared by the forwarding engine modules
`default_nettype none
`include "sfe_cfg.svh"

package sfe_pkg;

    typedef enum logic [1:0] {SFE_PT_FS, SFE_PT_FE, SFE_PT_LINE, SFE_PT_OTHER} sfe_ptype_t;

    typedef enum logic [1:0] {ST_IDLE, ST_WAIT_FS, ST_CHECK, ST_XFER} sfe_state_t;

    typedef enum logic [1:0] {SFE_PH_NONE, SFE_PH_FS, SFE_PH_LINE, SFE_PH_FE} sfe_phase_t;

    typedef struct packed {
        logic [`SFE_DATA_W-1:0] data;
        logic [1:0]             vc;
        sfe_ptype_t             ptype;
        logic                   last;
    } sfe_word_t;

    typedef struct packed {
        sfe_state_t             st;
        sfe_phase_t             ph_seq;
        logic [1:0]             cur;
        logic [1:0]             last_rr;
        logic                   half;
        logic                   drop;
        logic                   endw;
        logic                   synced;
        logic                   lost;
        logic [`SFE_NPORT-1:0]  rd;
        logic [7:0]             port_ctl;
        logic [7:0]             mode_ctl;
        logic [7:0]             rdata;
        logic                   ov;
        sfe_word_t              ow;
        logic                   hs;
    } sfe_core_t;

endpackage : sfe_pkg

`default_nettype wire

// [common/sfe_stream_if.sv]
// valid/ready word carrier between engine, fifo and output stage
`timescale 1ns/1ps
`default_nettype none

interface sfe_stream_if #(parameter int W = 8) ();
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : sfe_stream_if

`default_nettype wire

// [src/sfe_rr_arb.sv]
// rotating pick of the first requester after a pointer
`timescale 1ns/1ps
`default_nettype none

module sfe_rr_arb #(
    parameter int N = 4
) (
    input  wire logic [N-1:0]         req,   // request vector
    input  wire logic [$clog2(N)-1:0] ptr,   // last served index
    output var  logic [$clog2(N)-1:0] idx,   // chosen index
    output var  logic                 any    // some request present
);
    localparam int W = $clog2(N);

    // walk downward so the nearest index after ptr is written last
    always_comb begin
        int pos;
        pos = 0;
        idx = '0;
        any = 1'b0;
        for (int i = N; i >= 1; i--) begin
            pos = (int'(ptr) + i) % N;
            if (req[pos]) begin
                idx = W'(pos);
                any = 1'b1;
            end
        end
    end
endmodule : sfe_rr_arb

`default_nettype wire

// [src/sfe_fifo.sv]
// output word fifo, show-ahead read side
`timescale 1ns/1ps
`default_nettype none

module sfe_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input  wire logic  clk,   // core clock
    input  wire logic  rst,   // async reset, high
    sfe_stream_if.snk  wr,    // fill side
    sfe_stream_if.src  rd     // drain side
);
    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } sfe_fifo_st_t;

    sfe_fifo_st_t s, n;
    logic [W-1:0] mem [D];
    logic         push;
    logic         pop;

    // full and empty straight from the count, no look-ahead
    assign wr.ready = (s.cnt != (AW+1)'(D));
    assign rd.valid = (s.cnt != '0);
    assign rd.data  = mem[s.rp];
    assign push     = wr.valid & wr.ready;
    assign pop      = rd.valid & rd.ready;

    // pointers wrap naturally since depth is a power of two
    always_comb begin
        n     = s;
        n.wp  = s.wp + AW'(push);
        n.rp  = s.rp + AW'(pop);
        n.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= n;
            if (push) begin
                mem[s.wp] <= wr.data;
            end
        end
    end

    a_fifo_count: assert property (@(posedge clk) disable iff (rst)
        (push && !pop) |=> (s.cnt == $past(s.cnt) + (AW+1)'(1)))
        else $error("fifo count did not grow on push");
endmodule : sfe_fifo

`default_nettype wire

// [src/sfe_top.sv]
// CSI-2 forwarding engine: round-robin and basic synchronized forwarding
// How it works
// (RULE1) packets are read from each port buffer and delivered to the output
// (RULE2) engine drives the LP/HS request and forwards frame start/end short packets
// (RULE3) buffer availability of every port is watched before scheduling
// (RULE4) a set per-port disable bit removes that port from forwarding
// (RULE5) upper nibble maps each buffer to one transmitter only
// (RULE6) each engine instance keeps its own configuration and scheduling
// (RULE7) default mode is round-robin, streams told apart by VC and type
// (RULE8) round-robin sends ready packets at once, rotating over ports
// (RULE9) round-robin keeps per-VC frame packets and no cross-port alignment
// (RULE10) round-robin runs while its enable bit is set
// (RULE11) synchronized mode sends sync packets, then lines, in ascending port order
// (RULE12) sources must arrive aligned within a line, identical frame parameters
// (RULE13) on sync failure packets are discarded until the next frame start
// (RULE14) synced status bit and a sticky lost flag cleared by reading
// (RULE15) a two-bit field picks basic, interleaved or concatenated sync mode; the code runs basic forwarding for every nonzero code
// (RULE16) software clears round-robin, then port disables, then sets sync mode
// (RULE17) basic mode: all frame starts, lines port by port, all frame ends
// (RULE18) forwarded packets keep the VC of their receive port
// (RULE19) sensor n is receive port n; any subset of ports allowed
// (RULE20) any number of sources up to four may be synchronized
// (RULE21) a packet is pulled only once it is wholly in its buffer
// (RULE22) the synced status reads zero while sync mode is off
// (RULE23) round-robin pointer moves past the served port, skipping idle ones
`timescale 1ns/1ps
`default_nettype none

`include "sfe_cfg.svh"

module sfe_top #(
    parameter logic TX_SEL = 1'b0                      // map bit value that means this engine
) (
    input  wire logic                                sys_clk,     // core clock, 125 MHz
    input  wire logic                                sys_rst,     // async reset, high
    input  wire logic [7:0]                          reg_addr,    // register offset
    input  wire logic                                reg_wr,      // write strobe
    input  wire logic [7:0]                          reg_wdata,   // write data
    input  wire logic                                reg_rd,      // read strobe
    output var  logic [7:0]                          reg_rdata,   // read data, next cycle
    input  wire logic [`SFE_NPORT-1:0]               in_avail,    // whole packet held
    input  wire sfe_pkg::sfe_ptype_t [`SFE_NPORT-1:0] in_type,    // head packet kind
    input  wire logic [`SFE_NPORT-1:0][1:0]          in_vc,       // head packet VC
    input  wire logic [`SFE_NPORT-1:0][`SFE_DATA_W-1:0] in_data,  // head word
    input  wire logic [`SFE_NPORT-1:0]               in_last,     // head word ends packet
    output var  logic [`SFE_NPORT-1:0]               in_rd,       // pop head word
    output var  logic                                csi_valid,   // output word valid
    input  wire logic                                csi_ready,   // transmitter accepts
    output var  logic [`SFE_DATA_W-1:0]              csi_data,    // output word
    output var  logic [1:0]                          csi_vc,      // packet VC
    output var  sfe_pkg::sfe_ptype_t                 csi_type,    // packet kind
    output var  logic                                csi_last,    // last word of packet
    output var  logic                                hs_req,      // request HS state
    output var  logic                                sync_status  // engine synchronized
);
    import sfe_pkg::*;

    localparam int WW = $bits(sfe_word_t);

    sfe_core_t             s, n;
    sfe_word_t             pw;
    logic [`SFE_NPORT-1:0] dis, elig, cand, fs_head, bad;
    logic [1:0]            smode, rr_idx, nx_idx, first_idx, bad_idx;
    logic                  rr_en, sync_on, rr_any, elig_any, bad_any, all_fs;
    logic                  lost_set, sts_rd, ok;

    sfe_stream_if #(.W(WW)) push_if ();
    sfe_stream_if #(.W(WW)) pop_if ();

    // configuration decode
    assign dis     = s.port_ctl[`SFE_DIS_LSB +: `SFE_NPORT];
    assign elig    = ~dis & (TX_SEL ? s.port_ctl[`SFE_MAP_LSB +: `SFE_NPORT]
                                    : ~s.port_ctl[`SFE_MAP_LSB +: `SFE_NPORT]); // RULE4 RULE5 RULE6
    assign rr_en   = s.mode_ctl[`SFE_RR_EN_BIT];                                // RULE10
    assign smode   = s.mode_ctl[`SFE_SYNC_LSB +: 2];                            // RULE15
    assign sync_on = (smode != `SFE_SMODE_OFF);
    assign cand    = elig & in_avail;                                           // RULE3 RULE21
    assign bad     = cand & ~fs_head;
    assign all_fs  = elig_any && ((cand & fs_head) == elig);                    // RULE19 RULE20
    assign sts_rd  = reg_rd && (reg_addr == `SFE_ADDR_STATUS);

    always_comb begin
        for (int p = 0; p < `SFE_NPORT; p++) begin
            fs_head[p] = (in_type[p] == SFE_PT_FS);
        end
    end

    // next round-robin winner after the last served port
    sfe_rr_arb #(.N(`SFE_NPORT)) u_rr (
        .req (cand),
        .ptr (s.last_rr),
        .idx (rr_idx),
        .any (rr_any)
    );
    // next enabled port in ascending order during a synchronized pass
    sfe_rr_arb #(.N(`SFE_NPORT)) u_nx (
        .req (elig),
        .ptr (s.cur),
        .idx (nx_idx),
        .any ()
    );
    // lowest enabled port
    sfe_rr_arb #(.N(`SFE_NPORT)) u_first (
        .req (elig),
        .ptr (2'h3),
        .idx (first_idx),
        .any (elig_any)
    );
    // lowest port whose head is not a frame start, to be discarded
    sfe_rr_arb #(.N(`SFE_NPORT)) u_bad (
        .req (bad),
        .ptr (2'h3),
        .idx (bad_idx),
        .any (bad_any)
    );

    sfe_fifo #(.W(WW), .D(`SFE_FIFO_DEPTH)) u_fifo (
        .clk (sys_clk),
        .rst (sys_rst),
        .wr  (push_if),
        .rd  (pop_if)
    );

    // word from the port being served, VC taken from that port
    assign pw           = '{data: in_data[s.cur], vc: in_vc[s.cur],
                            ptype: in_type[s.cur], last: in_last[s.cur]};       // RULE18
    assign push_if.data = pw;

    // whole next-state of the engine
    always_comb begin
        n             = s;
        n.rd          = '0;
        lost_set      = 1'b0;
        ok            = 1'b0;
        push_if.valid = 1'b0;
        pop_if.ready  = !s.ov || csi_ready;

        if (reg_wr) begin
            case (reg_addr)
                `SFE_ADDR_PORT_CTL: n.port_ctl = reg_wdata;
                `SFE_ADDR_MODE_CTL: n.mode_ctl = reg_wdata;
                default: ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                `SFE_ADDR_PORT_CTL: n.rdata = s.port_ctl;
                `SFE_ADDR_MODE_CTL: n.rdata = s.mode_ctl;
                `SFE_ADDR_STATUS:   n.rdata = {6'h00, s.lost, s.synced};        // RULE14
                default:            n.rdata = 8'h00;
            endcase
        end

        case (s.st)
            ST_IDLE: begin
                n.ph_seq = SFE_PH_NONE;
                if (sync_on) begin
                    n.st = ST_WAIT_FS;
                end else if (rr_en && rr_any) begin                             // RULE7 RULE8 RULE9
                    n.cur  = rr_idx;                                            // RULE23
                    n.drop = 1'b0;
                    n.half = 1'b0;
                    n.st   = ST_XFER;
                end
            end
            ST_WAIT_FS: begin
                // stale heads are thrown away until every enabled port shows a frame start
                if (!sync_on) begin
                    n.st = ST_IDLE;
                end else if (bad_any) begin                                     // RULE13
                    n.cur  = bad_idx;
                    n.drop = 1'b1;
                    n.half = 1'b0;
                    n.st   = ST_XFER;
                end else if (all_fs) begin                                      // RULE17
                    n.cur    = first_idx;
                    n.ph_seq = SFE_PH_FS;
                    n.synced = 1'b1;
                    n.st     = ST_CHECK;
                end
            end
            ST_CHECK: begin
                // no timeout here: a silent port stalls the pass, it is not dropped
                if (!sync_on) begin
                    n.st = ST_IDLE;
                end else if (in_avail[s.cur]) begin
                    case (s.ph_seq)
                        SFE_PH_FS:   ok = (in_type[s.cur] == SFE_PT_FS);        // RULE11
                        SFE_PH_FE:   ok = (in_type[s.cur] == SFE_PT_FE);
                        default: begin
                            ok = (in_type[s.cur] == SFE_PT_LINE)
                              || (in_type[s.cur] == SFE_PT_OTHER);
                            if (in_type[s.cur] == SFE_PT_FE && s.cur == first_idx) begin
                                ok       = 1'b1;                                // RULE17
                                n.ph_seq = SFE_PH_FE;
                            end
                        end
                    endcase
                    if (ok) begin
                        n.drop = 1'b0;
                        n.half = 1'b0;
                        n.st   = ST_XFER;
                    end else begin
                        lost_set = 1'b1;                                        // RULE13
                        n.synced = 1'b0;
                        n.st     = ST_WAIT_FS;
                    end
                end
            end
            ST_XFER: begin
                if (!s.half) begin
                    // pop only when the fifo takes the word, or when discarding
                    if (s.drop || push_if.ready) begin
                        push_if.valid = !s.drop;                                // RULE1
                        n.rd[s.cur]   = 1'b1;
                        n.half        = 1'b1;
                        n.endw        = in_last[s.cur];
                    end
                end else begin
                    n.half = 1'b0;
                    if (s.endw) begin
                        n.endw = 1'b0;
                        if (s.drop) begin
                            n.st = sync_on ? ST_WAIT_FS : ST_IDLE;
                        end else if (s.ph_seq == SFE_PH_NONE || !sync_on) begin
                            n.last_rr = s.cur;                                  // RULE23
                            n.st      = ST_IDLE;
                        end else begin
                            n.cur = nx_idx;                                     // RULE11
                            n.st  = ST_CHECK;
                            if (nx_idx <= s.cur) begin
                                if (s.ph_seq == SFE_PH_FS) begin
                                    n.ph_seq = SFE_PH_LINE;
                                end else if (s.ph_seq == SFE_PH_FE) begin
                                    n.st = ST_WAIT_FS;
                                end
                            end
                        end
                    end
                end
            end
            default: n.st = ST_IDLE;
        endcase

        if (!sync_on) begin
            n.synced = 1'b0;                                                    // RULE22
        end
        // a loss in the reading cycle survives the clear
        n.lost = (s.lost && !sts_rd) || lost_set;                               // RULE14

        // output register refills whenever it is free or being taken
        if (pop_if.ready) begin
            n.ov = pop_if.valid;
            n.ow = sfe_word_t'(pop_if.data);
        end
        n.hs = n.ov || pop_if.valid || (n.st == ST_XFER && !n.drop);           // RULE2
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s          <= '0;
            s.port_ctl <= `SFE_PORT_CTL_RST;
            s.mode_ctl <= `SFE_MODE_CTL_RST;
        end else begin
            s <= n;
        end
    end

    assign reg_rdata   = s.rdata;
    assign in_rd       = s.rd;
    assign csi_valid   = s.ov;
    assign csi_data    = s.ow.data;
    assign csi_vc      = s.ow.vc;
    assign csi_type    = s.ow.ptype;
    assign csi_last    = s.ow.last;
    assign hs_req      = s.hs;
    assign sync_status = s.synced;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    sequence s_sync_start;
        (s.st == ST_WAIT_FS) && (n.st == ST_CHECK);
    endsequence
    sequence s_lost_evt;
        lost_set;
    endsequence
    sequence s_restart_wait;
        (s.st == ST_WAIT_FS) && !s.synced ##1 ((s.st != ST_XFER) || s.drop);
    endsequence

    a_sync_off_zero: assert property (!sync_on |=> !sync_status)                // RULE22
        else $error("sync status set while sync mode off");
    a_lost_sticky: assert property ((s.lost && !sts_rd) |=> s.lost)             // RULE14
        else $error("lost flag dropped without a read");
    a_lost_clear: assert property ((sts_rd && !lost_set) |=> !s.lost)          // RULE14
        else $error("lost flag not cleared by read");
    a_pull_whole: assert property ((s.st != ST_XFER && n.st == ST_XFER)
        |-> in_avail[n.cur])                                                    // RULE21
        else $error("packet pulled before it was complete");
    a_rr_enabled: assert property ((s.st == ST_IDLE && n.st == ST_XFER)
        |-> (elig[n.cur] && !dis[n.cur] && rr_en))                              // RULE4
        else $error("round-robin served a disabled port");
    a_rr_rotates: assert property ((s.st == ST_IDLE && n.st == ST_XFER
        && $countones(cand) > 1) |-> (n.cur != s.last_rr))                      // RULE23
        else $error("round-robin served the same port twice");
    a_fs_first: assert property (s_sync_start
        |=> (s.ph_seq == SFE_PH_FS && s.synced && s.cur == $past(first_idx)))   // RULE11
        else $error("synchronized pass did not start with frame starts");
    a_lost_restart: assert property (s_lost_evt |=> s_restart_wait)            // RULE13
        else $error("engine kept forwarding after sync loss");
    a_pop_onehot: assert property ((in_rd != '0)
        |-> ($onehot(in_rd) && $past(s.st) == ST_XFER && s.half))               // RULE1
        else $error("bad pop pattern");
    a_hs_cover: assert property (csi_valid |-> hs_req)                          // RULE2
        else $error("output word without HS request");
endmodule : sfe_top

`default_nettype wire

// [verification/sfe_sink.sv]
// host-side sink of the output word stream: prompt, slow or stalled acceptance
`timescale 1ns/1ps
`default_nettype none

module sfe_sink (
    input  wire logic       sys_clk,   // core clock
    input  wire logic [1:0] pace,      // 0 prompt, 1 slow, 2 stalled
    output var  logic       csi_ready  // accept strobe toward the engine
);
    logic [1:0] cnt_r;

    // slow pace takes one word in three, like a receiver busy with lane overhead
    always @(posedge sys_clk) begin
        #1;
        cnt_r = (cnt_r == 2'h2) ? 2'h0 : cnt_r + 2'h1;
        csi_ready = (pace == 2'h0) || (pace == 2'h1 && cnt_r == 2'h0);
    end

    // quiet until the first edge
    initial begin
        cnt_r = 2'h0;
        csi_ready = 1'b0;
    end
endmodule : sfe_sink

`default_nettype wire

// [verification/testbench.sv]
// self-checking bench: port buffer models, register traffic, output scoreboard
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import sfe_pkg::*;
    logic             sys_clk, sys_rst, reg_wr, reg_rd;
    logic             csi_valid, csi_ready, csi_last, hs_req, sync_status;
    logic [7:0]       reg_addr, reg_wdata, reg_rdata;
    logic [1:0]       pace, csi_vc;
    logic [3:0]       in_avail, in_last, in_rd;
    logic [31:0]      csi_data;
    logic [15:0]      lfsr;
    logic [3:0][1:0]  in_vc;
    logic [3:0][31:0] in_data;
    sfe_ptype_t [3:0] in_type;
    sfe_ptype_t       csi_type;
    sfe_word_t        q[4][$];
    sfe_word_t        exp_q[$];
    int               n_errors, n_compared;

    sfe_top dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_avail(in_avail),
        .in_type(in_type), .in_vc(in_vc), .in_data(in_data), .in_last(in_last), .in_rd(in_rd),
        .csi_valid(csi_valid), .csi_ready(csi_ready), .csi_data(csi_data), .csi_vc(csi_vc),
        .csi_type(csi_type), .csi_last(csi_last), .hs_req(hs_req), .sync_status(sync_status));
    sfe_sink sink_u (.sys_clk(sys_clk), .pace(pace), .csi_ready(csi_ready));

    always #4 sys_clk = ~sys_clk;

    function automatic logic [15:0] nx(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : nx

    task automatic check(input logic [36:0] seen, input logic [36:0] want);
        n_compared++;
        if (seen !== want) begin
            n_errors++;
            $display("ERROR %0t: saw %h, expected %h", $time, seen, want);
        end
    endtask : check

    task automatic end_sim();
        if (n_errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        tick(1);
        reg_wr = 1'b0;
        // let an edge pass so a following call never re-raises the strobe in this step
        tick(1);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] want);
        reg_addr = a;
        reg_rd = 1'b1;
        tick(1);
        reg_rd = 1'b0;
        check(37'(reg_rdata & m), 37'(want));
        tick(1);
    endtask : rd

    // whole packet into a port buffer at once; e notes it as an expected output
    task automatic pkt(input int p, input sfe_ptype_t k, input int n, input logic e);
        sfe_word_t w;
        for (int i = 0; i < n; i++) begin
            lfsr = nx(lfsr);
            w = '{{lfsr, ~lfsr}, 2'(3 - p), k, i == n - 1};
            q[p].push_back(w);
            if (e) exp_q.push_back(w);
        end
    endtask : pkt

    task automatic drain();
        for (int i = 0; i < 3000 && (exp_q.size() != 0 || in_avail != 4'h0); i++) tick(1);
        tick(4);
        check(37'(exp_q.size()), 37'h0);
    endtask : drain

    // show-ahead heads; an emptied buffer drives junk that keeps changing
    always @(posedge sys_clk) begin
        logic [3:0] pop;
        sfe_word_t  h;
        pop = in_rd;
        #1;
        for (int p = 0; p < 4; p++) begin
            if (pop[p] && q[p].size() != 0) q[p].pop_front();
            h = (q[p].size() != 0) ? q[p][0] : '{~in_data[p], in_vc[p], in_type[p], 1'b0};
            in_avail[p] = q[p].size() != 0;
            in_data[p] = h.data;
            in_vc[p]   = h.vc;
            in_type[p] = h.ptype;
            in_last[p] = h.last;
        end
    end

    // scoreboard: each accepted word must be the oldest note
    always @(posedge sys_clk) begin
        if (!sys_rst && csi_valid === 1'b1 && csi_ready === 1'b1) begin
            check(37'(hs_req), 37'h1);
            if (exp_q.size() == 0) check(37'h1, 37'h0);
            else check({csi_data, csi_vc, csi_type, csi_last}, exp_q.pop_front());
        end
    end

    // watchdog at 20000 cycles, far beyond the expected run
    initial begin
        tick(20000);
        n_errors++;
        $display("ERROR %0t: run hung", $time);
        end_sim();
    end

    initial begin
        {sys_clk, reg_wr, reg_rd, reg_addr, reg_wdata, pace, n_errors, n_compared} = '0;
        {in_avail, in_vc, in_data, in_last} = '0;
        in_type = '{default: SFE_PT_OTHER};
        {sys_rst, lfsr} = {1'b1, 16'h0058};
        tick(4);
        sys_rst = 1'b0;
        // reset values, an unmapped offset, idle sync status
        rd(8'h20, 8'hFF, 8'h00);
        rd(8'h21, 8'hFF, 8'h01);
        rd(8'h35, 8'hFF, 8'h00);
        rd(8'h10, 8'hFF, 8'h00);
        check(37'(sync_status), 37'h0);
        // lone packet on port 2, then three ports at once under slow acceptance
        pkt(2, SFE_PT_LINE, 2, 1'b1);
        drain();
        pace = 2'h1;
        pkt(3, SFE_PT_LINE, 3, 1'b1);
        pkt(0, SFE_PT_FS, 1, 1'b1);
        pkt(1, SFE_PT_LINE, 2, 1'b1);
        drain();
        // round-robin off: the packet waits in its buffer
        wr(8'h21, 8'h00);
        pkt(0, SFE_PT_LINE, 1, 1'b1);
        tick(20);
        check(37'(q[0].size()), 37'h1);
        wr(8'h21, 8'h01);
        drain();
        // port 1 disabled and port 0 mapped away, then both released
        wr(8'h20, 8'h12);
        pkt(2, SFE_PT_FE, 1, 1'b1);
        pkt(0, SFE_PT_LINE, 1, 1'b1);
        pkt(1, SFE_PT_LINE, 1, 1'b1);
        tick(30);
        check(37'(q[0].size() + q[1].size()), 37'h2);
        wr(8'h20, 8'h00);
        drain();
        // stalled sink: fifo fills and the engine stops popping
        pace = 2'h2;
        pkt(3, SFE_PT_LINE, 12, 1'b1);
        tick(60);
        check(37'(q[3].size() != 0), 37'h1);
        pace = 2'h0;
        drain();
        // one aligned frame per sync mode code, enabled in the advised order
        wr(8'h21, 8'h00);
        wr(8'h20, 8'h00);
        for (int m = 1; m < 4; m++) begin
            wr(8'h21, 8'(m << 4));
            for (int k = 0; k < 3; k++) begin
                for (int p = 0; p < 4; p++) begin
                    pkt(p, k == 0 ? SFE_PT_FS : k == 1 ? SFE_PT_LINE : SFE_PT_FE,
                        k == 1 ? 2 : 1, 1'b1);
                end
            end
            drain();
        end
        rd(8'h35, 8'hFF, 8'h01);
        check(37'(sync_status), 37'h1);
        // two-port subset whose second port ends its frame early
        // everything before the early frame end goes out; that frame end is discarded
        wr(8'h20, 8'h0C);
        pkt(0, SFE_PT_FS, 1, 1'b1);
        pkt(1, SFE_PT_FS, 1, 1'b1);
        pkt(0, SFE_PT_LINE, 2, 1'b1);
        pkt(1, SFE_PT_FE, 1, 1'b0);
        tick(60);
        check(37'(exp_q.size()), 37'h0);
        check(37'(q[1].size()), 37'h0);
        rd(8'h35, 8'h02, 8'h02);
        rd(8'h35, 8'h02, 8'h00);
        end_sim();
    end
endmodule : testbench

`default_nettype wire
